//--- rtl/dio_defs.svh
// Register offsets, field positions, reset values and timing counts
// for the digital I/O port controller. Definitions only.
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH

// Byte offsets on the register bus; DIO_OFF_BIBIT is address bits 7:4
`define DIO_OFF_CTRL 8'h00
`define DIO_OFF_DPOL 8'h04
`define DIO_OFF_BIPORT 8'h08
`define DIO_OFF_STATUS 8'h0c
`define DIO_OFF_BIBIT 4'h1
`define DIO_OFF_CMD 8'h20
`define DIO_OFF_WDATA 8'h24
`define DIO_OFF_RDATA 8'h28

// Control register fields
`define DIO_CTRL_MODE_LSB 0
`define DIO_CTRL_SPOL 3
`define DIO_CTRL_FPOL 4
`define DIO_CTRL_IOPOL 5
`define DIO_CTRL_MRST 8
`define DIO_CTRL_SCAN 9
`define DIO_CTRL_PAIR 10

// Data polarity register: one bit per 8-bit port, then built-in port
`define DIO_DPOL_BI 4

// Status register fields
`define DIO_STAT_BUSY 0
`define DIO_STAT_ERR 1
`define DIO_STAT_FLAG 2
`define DIO_STAT_SCANOK 3
`define DIO_STAT_PDIR_LSB 8
`define DIO_STAT_BDIR_LSB 12

// Transfer command fields and width codes
`define DIO_CMD_WR 0
`define DIO_CMD_PORT_LSB 1
`define DIO_CMD_WIDTH_LSB 3
`define DIO_WIDTH_8 2'h0
`define DIO_WIDTH_16 2'h1
`define DIO_WIDTH_32 2'h2

// Reset values
`define DIO_MODE_RST 3'h1
`define DIO_POL_RST 1'h0

// Strobe timing in system clock cycles
`define DIO_STB_CYC 8'h02
`define DIO_SETUP_CYC 8'h01

`endif

//--- rtl/dio_pkg.sv
// Types shared by the digital I/O port controller and its sequencer.
// Assumes dio_defs.svh carries the numeric constants.
package dio_pkg;

   typedef enum logic [2:0] {
      DIO_MODE1 = 3'h1,
      DIO_MODE2 = 3'h2,
      DIO_MODE3 = 3'h3,
      DIO_MODE4 = 3'h4,
      DIO_MODE5 = 3'h5
   } dio_mode_t;

   typedef enum logic [2:0] {
      DIO_IDLE   = 3'b000,
      DIO_SETUP  = 3'b001,
      DIO_STROBE = 3'b010,
      DIO_SAMPLE = 3'b011,
      DIO_DONE   = 3'b100
   } dio_state_t;

   // Sequencer view of the control lines, logical (positive) levels
   typedef struct packed {
      logic busy;
      logic sample;
      logic dir;
      logic stb;
      logic done;
   } dio_hs_t;

   typedef struct packed {
      logic [1:0] width;
      logic [1:0] port;
      logic write;
   } dio_cmd_t;

endpackage

//--- rtl/dio_hs.sv
// Handshake sequencer for the plug-in port group: times direction line,
// strobe pulse and input sampling for modes 1 to 4.
// Assumes the caller starts it only when idle and only with modes 1-4.
`timescale 1ns/1ps
`default_nettype none
`include "dio_defs.svh"

module dio_hs import dio_pkg::*; #(
   parameter logic [7:0] STB_CYC = `DIO_STB_CYC,
   parameter logic [7:0] SETUP_CYC = `DIO_SETUP_CYC
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic start,
   input wire logic cmd_write,
   input wire dio_mode_t mode,
   output dio_hs_t hs
);

   dio_state_t state_q;
   logic [7:0] cnt_q;
   logic wr_q;
   dio_mode_t mode_q;
   logic dir_q;
   logic strobed;

   assign strobed = (mode == DIO_MODE3) || (mode == DIO_MODE4);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_q <= DIO_IDLE;
         cnt_q <= 8'h00;
         wr_q <= 1'b0;
         mode_q <= DIO_MODE1;
      end else begin
         case (state_q)
            DIO_IDLE: begin
               if (start) begin
                  wr_q <= cmd_write;
                  mode_q <= mode;
                  if (cmd_write && strobed) begin
                     state_q <= DIO_SETUP;
                     cnt_q <= SETUP_CYC - 8'h01;
                  end else if (cmd_write) begin
                     state_q <= DIO_DONE;
                  end else begin
                     // Drivers of a just-written port need a cycle to let go
                     state_q <= DIO_SETUP;
                     cnt_q <= SETUP_CYC - 8'h01;
                  end
               end
            end
            DIO_SETUP: begin
               if (cnt_q == 8'h00) begin
                  if (wr_q) begin
                     state_q <= DIO_STROBE;
                  end else begin
                     state_q <= DIO_SAMPLE;
                  end
                  cnt_q <= STB_CYC - 8'h01;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            DIO_SAMPLE: begin
               if ((mode_q == DIO_MODE3) || (mode_q == DIO_MODE4)) begin
                  state_q <= DIO_STROBE;
                  cnt_q <= STB_CYC - 8'h01;
               end else begin
                  state_q <= DIO_DONE;
               end
            end
            DIO_STROBE: begin
               if (cnt_q == 8'h00) begin
                  state_q <= DIO_DONE;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            DIO_DONE: state_q <= DIO_IDLE;
            default: state_q <= DIO_IDLE;
         endcase
      end
   end

   // Direction level; mode 2 reads leave it alone, mode 4 parks it low
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         dir_q <= 1'b0;
      end else if (state_q == DIO_IDLE && start) begin
         if (mode == DIO_MODE4) begin
            dir_q <= 1'b0;
         end else if (cmd_write) begin
            dir_q <= 1'b1;
         end else if (mode != DIO_MODE2) begin
            dir_q <= 1'b0;
         end
      end
   end

   always_comb begin
      hs.busy = (state_q != DIO_IDLE);
      hs.sample = (state_q == DIO_SAMPLE);
      hs.done = (state_q == DIO_DONE);
      // Mode 4 write strobe rides on the direction line
      if (mode_q == DIO_MODE4) begin
         hs.dir = (state_q == DIO_STROBE) && wr_q;
         hs.stb = (state_q == DIO_STROBE) && !wr_q;
      end else begin
         hs.dir = dir_q;
         hs.stb = (state_q == DIO_STROBE);
      end
   end

endmodule // dio_hs
`default_nettype wire

//--- rtl/dio_top.sv
// Digital I/O port controller: built-in 4-bit port plus a plug-in group
// of four 8-bit ports with handshake lines, behind an Avalon-MM slave.
// Assumes pins are synchronous to clk_sys; pad logic resolves the
// data pins from the *_oe outputs.
//
// Summary of operation
// - Built-in port has four bits, usable as four bit channels or one port.
// - All bits of one 8-bit port share a single direction.
// - Each plug-in port keeps its own direction independent of others.
// - Mode and control line polarities apply only to plug-in ports.
// - Each port has its own data polarity; negative inverts its data lines.
// - Reset selects mode one and positive polarity on all lines.
// - Control, flag and direction polarity: 1 means negative, 0 positive.
// - Five flow-control modes using direction, flag and strobe lines; here mode 5 refuses transfers and the flag line only shows in status.
// - Modes 3, 4 and 5 exclude the port from scanning and pairing.
// - Mode one is static; direction line shows transfer direction.
// - Mode two keeps output drivers on during reads.
// - Mode two direction line acts as mode one on writes, holds on reads.
// - Mode three shows direction and times transfers with the strobe.
// - Mode three write strobes only while output data is valid.
// - Mode three read strobes after the input has been sampled.
// - Mode four pulses direction as write strobe, strobe line as read.
// - Reset makes all ports inputs; module reset does so for its ports.
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dio_defs.svh"

module dio_top import dio_pkg::*; (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [31:0] mod_data_i,
   output logic [31:0] mod_data_o,
   output logic [31:0] mod_data_oe,
   output logic dir_line_o,
   output logic peripheral_strobe_line_o,
   input wire logic peripheral_flag_line_i,
   input wire logic [3:0] bi_data_i,
   output logic [3:0] bi_data_o,
   output logic [3:0] bi_data_oe
);

   logic [31:0] wmask;
   logic [31:0] wdm;
   logic req, acc, wr_acc, rd_acc, hold;
   logic hit_ctrl, hit_dpol, hit_bi, hit_stat, hit_bit;
   logic hit_cmd, hit_wd, hit_rd;
   logic [1:0] bit_idx;

   dio_mode_t mode_q;
   logic spol_q, fpol_q, iopol_q, scan_q, pair_q;
   logic [4:0] dpol_q;
   logic [3:0] pdir_q;
   logic [3:0] bdir_q;
   logic [3:0] bval_q;
   logic [31:0] mval_q;
   logic [31:0] wdata_q;
   logic [31:0] rdata_q;
   dio_cmd_t cmd_q;
   logic start_q;
   logic err_q;
   logic [31:0] rd_d;
   logic [3:0] lanes;
   logic [4:0] shamt;
   logic [31:0] polmask;
   logic [31:0] lanemask;
   logic [2:0] new_mode;
   logic mode_ok;
   logic scan_bad;
   logic start_bad;
   dio_cmd_t new_cmd;
   dio_hs_t hs;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign wmask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
         assign polmask[gi*8 +: 8] = {8{dpol_q[gi]}};
         assign lanemask[gi*8 +: 8] = {8{lanes[gi]}};
      end
   endgenerate

   assign wdm = avs_writedata & wmask;
   assign req = avs_read | avs_write;
   assign hit_ctrl = (avs_address == `DIO_OFF_CTRL);
   assign hit_dpol = (avs_address == `DIO_OFF_DPOL);
   assign hit_bi = (avs_address == `DIO_OFF_BIPORT);
   assign hit_stat = (avs_address == `DIO_OFF_STATUS);
   assign hit_bit = (avs_address[7:4] == `DIO_OFF_BIBIT);
   assign hit_cmd = (avs_address == `DIO_OFF_CMD);
   assign hit_wd = (avs_address == `DIO_OFF_WDATA);
   assign hit_rd = (avs_address == `DIO_OFF_RDATA);
   assign bit_idx = avs_address[3:2];

   // A new transfer command waits on the bus until the sequencer is free
   assign hold = hit_cmd & avs_write & (hs.busy | start_q);
   assign acc = req & avs_waitrequest & ~hold;
   assign wr_acc = acc & avs_write;
   assign rd_acc = acc & avs_read;

   assign new_mode = wdm[`DIO_CTRL_MODE_LSB +: 3];
   assign mode_ok = (new_mode >= 3'h1) && (new_mode <= 3'h5);
   assign new_cmd = dio_cmd_t'(wdm[`DIO_CMD_WR +: 5]);
   assign start_bad = hit_cmd & wr_acc & (mode_q == DIO_MODE5);
   assign scan_bad = hit_ctrl & wr_acc
      & (wdm[`DIO_CTRL_SCAN] | wdm[`DIO_CTRL_PAIR])
      & ((mode_ok ? new_mode : mode_q) >= 3'h3);

   // Lanes touched by a command: single port, aligned pair, or all four
   always_comb begin
      case (cmd_q.width)
         `DIO_WIDTH_8: begin
            lanes = 4'h1 << cmd_q.port;
            shamt = {cmd_q.port, 3'h0};
         end
         `DIO_WIDTH_16: begin
            lanes = cmd_q.port[1] ? 4'hc : 4'h3;
            shamt = {cmd_q.port[1], 4'h0};
         end
         default: begin
            lanes = 4'hf;
            shamt = 5'h00;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~acc;
      end
   end

   // Module configuration; the built-in port has no such settings
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mode_q <= dio_mode_t'(`DIO_MODE_RST);
         spol_q <= `DIO_POL_RST;
         fpol_q <= `DIO_POL_RST;
         iopol_q <= `DIO_POL_RST;
         scan_q <= 1'b0;
         pair_q <= 1'b0;
      end else if (wr_acc && hit_ctrl) begin
         if (mode_ok) begin
            mode_q <= dio_mode_t'(new_mode);
         end
         if (avs_byteenable[0]) begin
            spol_q <= wdm[`DIO_CTRL_SPOL];
            fpol_q <= wdm[`DIO_CTRL_FPOL];
            iopol_q <= wdm[`DIO_CTRL_IOPOL];
         end
         if (avs_byteenable[1]) begin
            scan_q <= wdm[`DIO_CTRL_SCAN] & ~scan_bad;
            pair_q <= wdm[`DIO_CTRL_PAIR] & ~scan_bad;
         end else if (mode_ok && new_mode >= 3'h3) begin
            scan_q <= 1'b0;
            pair_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         dpol_q <= 5'h00;
      end else if (wr_acc && hit_dpol && avs_byteenable[0]) begin
         dpol_q <= wdm[4:0];
      end
   end

   // Error flag: a new error in the clearing cycle keeps it set
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         err_q <= 1'b0;
      end else if (start_bad || scan_bad) begin
         err_q <= 1'b1;
      end else if (wr_acc && hit_stat && wdm[`DIO_STAT_ERR]) begin
         err_q <= 1'b0;
      end
   end

   // Built-in port: a port access moves all four bits, a bit channel one
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bdir_q <= 4'h0;
         bval_q <= 4'h0;
      end else if (acc && hit_bi) begin
         bdir_q <= {4{avs_write}};
         if (avs_write && avs_byteenable[0]) begin
            bval_q <= wdm[3:0];
         end
      end else if (acc && hit_bit) begin
         bdir_q[bit_idx] <= avs_write;
         if (avs_write && avs_byteenable[0]) begin
            bval_q[bit_idx] <= wdm[0];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cmd_q <= '0;
         wdata_q <= 32'h0000_0000;
         start_q <= 1'b0;
      end else begin
         start_q <= wr_acc & hit_cmd & (mode_q != DIO_MODE5);
         if (wr_acc && hit_cmd) begin
            cmd_q <= new_cmd;
         end
         if (wr_acc && hit_wd) begin
            wdata_q <= (wdata_q & ~wmask) | wdm;
         end
      end
   end

   // Port directions and output latch change as the transfer starts,
   // so data is on the lines before any strobe
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pdir_q <= 4'h0;
         mval_q <= 32'h0000_0000;
      end else if (wr_acc && hit_ctrl && wdm[`DIO_CTRL_MRST]) begin
         pdir_q <= 4'h0;
      end else if (start_q) begin
         if (cmd_q.write) begin
            pdir_q <= pdir_q | lanes;
            mval_q <= (mval_q & ~lanemask)
               | ((wdata_q << shamt) & lanemask);
         end else if (mode_q != DIO_MODE2) begin
            pdir_q <= pdir_q & ~lanes;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rdata_q <= 32'h0000_0000;
      end else if (hs.sample) begin
         // In mode 2 this reads back our own drive if the peripheral is off
         rdata_q <= (((mod_data_i ^ polmask) & lanemask) >> shamt);
      end
   end

   // Pin drivers, all from flip-flops
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pin
         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               mod_data_oe[gi*8 +: 8] <= 8'h00;
               bi_data_oe[gi] <= 1'b0;
            end else begin
               mod_data_oe[gi*8 +: 8] <= {8{pdir_q[gi]}};
               bi_data_oe[gi] <= bdir_q[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mod_data_o <= 32'h0000_0000;
         bi_data_o <= 4'h0;
         dir_line_o <= 1'b0;
         peripheral_strobe_line_o <= 1'b0;
      end else begin
         mod_data_o <= mval_q ^ polmask;
         bi_data_o <= bval_q ^ {4{dpol_q[`DIO_DPOL_BI]}};
         dir_line_o <= hs.dir ^ iopol_q;
         peripheral_strobe_line_o <= hs.stb ^ spol_q;
      end
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_d[`DIO_CTRL_MODE_LSB +: 3] = mode_q;
         rd_d[`DIO_CTRL_SPOL] = spol_q;
         rd_d[`DIO_CTRL_FPOL] = fpol_q;
         rd_d[`DIO_CTRL_IOPOL] = iopol_q;
         rd_d[`DIO_CTRL_SCAN] = scan_q;
         rd_d[`DIO_CTRL_PAIR] = pair_q;
      end else if (hit_dpol) begin
         rd_d[4:0] = dpol_q;
      end else if (hit_bi) begin
         rd_d[3:0] = bi_data_i ^ {4{dpol_q[`DIO_DPOL_BI]}};
      end else if (hit_bit) begin
         rd_d[0] = bi_data_i[bit_idx] ^ dpol_q[`DIO_DPOL_BI];
      end else if (hit_stat) begin
         rd_d[`DIO_STAT_BUSY] = hs.busy | start_q;
         rd_d[`DIO_STAT_ERR] = err_q;
         rd_d[`DIO_STAT_FLAG] = peripheral_flag_line_i ^ fpol_q;
         rd_d[`DIO_STAT_SCANOK] = (mode_q <= DIO_MODE2);
         rd_d[`DIO_STAT_PDIR_LSB +: 4] = pdir_q;
         rd_d[`DIO_STAT_BDIR_LSB +: 4] = bdir_q;
      end else if (hit_cmd) begin
         rd_d[4:0] = cmd_q;
      end else if (hit_wd) begin
         rd_d = wdata_q;
      end else if (hit_rd) begin
         rd_d = rdata_q;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_acc) begin
         avs_readdata <= rd_d;
      end
   end

   dio_hs u_hs (
      .clk_sys(clk_sys),
      .reset(reset),
      .start(start_q),
      .cmd_write(cmd_q.write),
      .mode(mode_q),
      .hs(hs)
   );

endmodule // dio_top
`default_nettype wire

//--- dv/dio_periph.sv
// Peripheral model on the plug-in data lines of the port controller.
// Assumes the bench hands it the controller's data outputs and enables.
`timescale 1ns/1ps
`default_nettype none
module dio_periph (
   input wire logic [31:0] drv_val,
   input wire logic [31:0] data_o,
   input wire logic [31:0] data_oe,
   output logic [31:0] line
);
   // Backs off wherever the controller drives, so no mode two read is
   // corrupted by a fight on the wire
   always_comb line = (data_oe & data_o) | (~data_oe & drv_val);
endmodule // dio_periph
`default_nettype wire

//--- dv/dio_top_chk.sv
// Assertion checker for the digital I/O port controller.
// Assumes it is bound onto dio_top and CTRL is written on byte lane 0.
`timescale 1ns/1ps
`default_nettype none
module dio_top_chk (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest,
   input wire logic [31:0] mod_data_oe,
   input wire logic [3:0] bi_data_oe,
   input wire logic dir_line_o,
   input wire logic peripheral_strobe_line_o
);
   logic [2:0] mode_q;
   logic spol_q;
   logic ipol_q;
   logic [2:0] age_q;
   logic ctrl_wr;
   logic settled;
   logic stb_on;
   logic dir_on;
   assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == 8'h00
      && avs_byteenable[0];
   assign settled = age_q[2];
   assign stb_on = peripheral_strobe_line_o ^ spol_q;
   assign dir_on = dir_line_o ^ ipol_q;
   // Pins lag a CTRL write, so line checks pause for a few cycles after it
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mode_q <= 3'h1;
         spol_q <= 1'b0;
         ipol_q <= 1'b0;
         age_q <= 3'h0;
      end else if (ctrl_wr) begin
         if (avs_writedata[2:0] != 3'h0 && avs_writedata[2:0] < 3'h6)
            mode_q <= avs_writedata[2:0];
         spol_q <= avs_writedata[3];
         ipol_q <= avs_writedata[5];
         age_q <= 3'h0;
      end else if (!settled) begin
         age_q <= age_q + 3'h1;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence stb_pulse;
      stb_on [*2] ##1 !stb_on;
   endsequence
   sequence dir_pulse;
      dir_on [*2] ##1 !dir_on;
   endsequence
   wait_one_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   ack_req_a: assert property (!avs_waitrequest |-> avs_read || avs_write)
      else $error("waitrequest low without a request");
   rst_in_a: assert property ($fell(reset) |-> mod_data_oe == 32'h0 &&
      bi_data_oe == 4'h0 && !dir_line_o && !peripheral_strobe_line_o)
      else $error("ports not inputs with idle lines after reset");
   byte_dir_a: assert property (mod_data_oe == {{8{mod_data_oe[24]}},
      {8{mod_data_oe[16]}}, {8{mod_data_oe[8]}}, {8{mod_data_oe[0]}}})
      else $error("bits of one port differ in direction");
   stb_width_a: assert property (settled && $rose(stb_on) |-> stb_pulse)
      else $error("strobe pulse not two cycles wide");
   static_quiet_a: assert property (settled && mode_q <= 3'h2 |-> !stb_on)
      else $error("strobe active in a static mode");
   m3_valid_a: assert property (settled && mode_q == 3'h3 &&
      stb_on && dir_on |-> mod_data_oe != 32'h0 && $stable(dir_line_o))
      else $error("write strobe without driven data or steady direction");
   m4_wstb_a: assert property (settled && mode_q == 3'h4 &&
      $rose(dir_on) |-> dir_pulse)
      else $error("write strobe on direction line malformed");
endmodule // dio_top_chk
bind dio_top dio_top_chk dio_top_chk_inst (
   .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_waitrequest(avs_waitrequest), .mod_data_oe(mod_data_oe),
   .bi_data_oe(bi_data_oe), .dir_line_o(dir_line_o),
   .peripheral_strobe_line_o(peripheral_strobe_line_o)
);
`default_nettype wire

//--- dv/dio_top_tb.sv
// Self-checking bench for dio_top with a peripheral model on its pins.
// Assumes the hand-over timing of the register bus and transfers.
`timescale 1ns/1ps
`default_nettype none
module dio_top_tb;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [31:0] mod_data_i;
   logic [31:0] mod_data_o;
   logic [31:0] mod_data_oe;
   logic dir_line_o;
   logic peripheral_strobe_line_o;
   logic peripheral_flag_line_i = 1'b0;
   logic [3:0] bi_data_i = 4'h0;
   logic [3:0] bi_data_o;
   logic [3:0] bi_data_oe;
   logic [31:0] periph_val = 32'h0;
   logic poll = 1'b0;
   logic [31:0] exp_q[$];
   int errors = 0;
   int checks = 0;
   int stb_n = 0;
   int dir_n = 0;
   always #2 clk_sys = ~clk_sys;
   always @(posedge peripheral_strobe_line_o) stb_n++;
   always @(posedge dir_line_o) dir_n++;
   dio_top dio_top_inst (.clk_sys(clk_sys), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .mod_data_i(mod_data_i),
      .mod_data_o(mod_data_o), .mod_data_oe(mod_data_oe),
      .dir_line_o(dir_line_o),
      .peripheral_strobe_line_o(peripheral_strobe_line_o),
      .peripheral_flag_line_i(peripheral_flag_line_i),
      .bi_data_i(bi_data_i), .bi_data_o(bi_data_o), .bi_data_oe(bi_data_oe));
   dio_periph dio_periph_inst (.drv_val(periph_val), .data_o(mod_data_o),
      .data_oe(mod_data_oe), .line(mod_data_i));
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 300) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 300) errors++;
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   // Expected values are masked so only documented fields are judged
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
      logic [31:0] q;
      exp_q.push_back(m);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0, q);
   endtask
   always @(posedge clk_sys) begin : rd_mon
      logic [31:0] msk;
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && !poll &&
         exp_q.size() > 1) begin
         msk = exp_q.pop_front();
         check("readdata", avs_readdata & msk, exp_q.pop_front());
      end
   end
   task automatic xfer(input logic w, input logic [1:0] p,
      input logic [31:0] d);
      logic [31:0] q;
      int n;
      wr(8'h24, d);
      wr(8'h20, {29'h0, p, w});
      poll = 1'b1;
      q = 32'h1;
      n = 0;
      while (q[0] !== 1'b0 && n < 50) begin
         bus(1'b0, 8'h0c, 32'h0, q);
         n++;
      end
      if (n >= 50) errors++;
      poll = 1'b0;
   endtask
   initial begin
      logic [31:0] d;
      logic [31:0] v;
      logic [1:0] p;
      int s;
      s = $urandom(32'h45ac);
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      rd(8'h00, 32'h1, 32'h3f);
      check("oe", mod_data_oe, 32'h0);
      check("lines", {dir_line_o, peripheral_strobe_line_o}, 32'h0);
      wr(8'h40, 32'hffffffff);
      rd(8'h40, 32'h0, 32'hffffffff);
      for (int m = 1; m <= 2; m++) begin
         for (int pol = 0; pol < 2; pol++) begin
            p = $urandom_range(3);
            d = $urandom_range(255);
            v = $urandom();
            // Module reset first, so mode 2 outputs of the last pass go away
            wr(8'h00, m | 32'h100);
            wr(8'h04, pol << p);
            xfer(1'b1, p, d);
            check("oe", mod_data_oe, 32'hff << (8 * p));
            check("data", (mod_data_o >> (8 * p)) & 32'hff,
               d ^ (pol ? 32'hff : 32'h0));
            check("dir", dir_line_o, 32'h1);
            periph_val <= v;
            xfer(1'b0, p, 32'h0);
            check("oe", mod_data_oe, m == 2 ? 32'hff << (8 * p) : 0);
            check("dir", dir_line_o, m == 2);
            rd(8'h28, m == 2 ? d : ((v >> (8 * p)) ^ (pol ? 32'hff : 0))
               & 32'hff, 32'hff);
         end
      end
      wr(8'h04, 32'h0);
      for (int m = 3; m <= 4; m++) begin
         wr(8'h00, m);
         for (int w = 1; w >= 0; w--) begin
            s = stb_n;
            d = dir_n;
            xfer(w, 2'h1, 32'h5a);
            check("strobes", stb_n - s, m == 3 || w == 0);
            if (m == 4) check("wstrobes", dir_n - d, w);
         end
      end
      wr(8'h00, 32'h203);
      rd(8'h00, 32'h3, 32'h207);
      rd(8'h0c, 32'h2, 32'ha);
      wr(8'h0c, 32'h2);
      wr(8'h00, 32'h1);
      wr(8'h00, 32'h201);
      rd(8'h0c, 32'h8, 32'ha);
      wr(8'h00, 32'h5);
      wr(8'h20, 32'h1);
      rd(8'h0c, 32'h2, 32'h3);
      peripheral_flag_line_i <= 1'b1;
      wr(8'h08, 32'ha);
      wr(8'h14, 32'h0);
      wr(8'h04, 32'h10);
      wr(8'h00, 32'h139);
      rd(8'h0c, 32'hf000, 32'hff04);
      check("pol", {dir_line_o, peripheral_strobe_line_o}, 32'h3);
      check("oe", mod_data_oe, 32'h0);
      check("builtin", {bi_data_oe, bi_data_o}, 32'hf7);
      wr(8'h04, 32'h0);
      v = $urandom_range(15);
      bi_data_i <= v[3:0];
      rd(8'h08, v, 32'hf);
      rd(8'h0c, 32'h0, 32'hf000);
      close_out();
   end
   initial begin
      #200000;
      errors++;
      close_out();
   end
endmodule // dio_top_tb
`default_nettype wire
